// ==== src/scsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsc_top #(
   parameter int unsigned INT_PERIOD_CYC = scsc_pkg::INT_PERIOD_CYC,
   parameter int unsigned ACC_PERIOD_CYC = scsc_pkg::ACC_PERIOD_CYC,
   parameter int unsigned DATA_W         = 16
) (
   input  wire logic              CORE_CLK_I,       // core clock
   input  wire logic              RST_I,            // sync reset, high
   input  wire logic              SPI_CS_N_I,       // serial select
   input  wire logic              SPI_SCLK_I,       // serial clock
   input  wire logic              SPI_DIN_I,        // serial data in
   output logic                   SPI_DOUT_O,       // serial data out
   input  wire logic              SYNC_I,           // sample pin level
   output logic                   SYNC_O,           // sample pin drive
   output logic                   SYNC_OE_N_O,      // low while driving
   input  wire logic [1:0]        GYRO_RANGE_I,     // range strap
   input  wire logic [DATA_W-1:0] GYRO_RAW_I,       // raw gyro sample
   input  wire logic [DATA_W-1:0] ACCEL_RAW_I,      // raw accel sample
   output logic [DATA_W-1:0]      GYRO_FILT_O,      // filtered gyro
   output logic [DATA_W-1:0]      ACCEL_AVG_O,      // accel update
   output logic                   ACCEL_VALID_O,    // accel update pulse
   output logic                   DATA_VALID_PIN_O, // data valid pin
   output logic                   LIN_G_COMP_EN_O,  // gyro g comp on
   output logic                   POP_ALIGN_EN_O,   // accel align on
   output logic                   BW_LIMIT_EN_O,    // 370 Hz bandwidth
   output logic                   SAMPLE_TICK_O     // sample clock pulse
);
   import scsc_pkg::*;

   if (ACC_PERIOD_CYC < 2 ||
       INT_PERIOD_CYC != 2 * ACC_PERIOD_CYC) begin : g_bad_period
      $error("scsc_top: internal period must be twice accel period");
   end
   if (DATA_W < 2) begin : g_bad_width
      $error("scsc_top: DATA_W too small");
   end

   // ---------------- serial port and registers ----------------
   logic             wr_stb;
   logic             rd_stb;
   logic [6:0]       addr;
   logic [7:0]       wdata;
   logic [15:0]      rd_word;
   logic [15:0]      rd_word_reg;
   logic [2:0]       filt_b_reg;
   logic [7:0]       misc_reg;
   logic [15:0]      scale_reg;
   logic [1:0]       range_reg;

   scsc_spi_slave u_spi (
      .clk_i     (CORE_CLK_I),
      .rst_i     (RST_I),
      .cs_n_i    (SPI_CS_N_I),
      .sclk_i    (SPI_SCLK_I),
      .din_i     (SPI_DIN_I),
      .rd_data_i (rd_word_reg),
      .dout_o    (SPI_DOUT_O),
      .wr_stb_o  (wr_stb),
      .rd_stb_o  (rd_stb),
      .addr_o    (addr),
      .data_o    (wdata)
   );

   // the strap is static; caught while reset is held
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         range_reg <= GYRO_RANGE_I;
      end
   end

   // bit 5 is stored as written; keeping it zero is up to software
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         filt_b_reg <= FILT_RESET;
         misc_reg   <= MISC_RESET;
         scale_reg  <= SCALE_RESET;
      end else if (wr_stb) begin
         case (addr)
            FILT_LO:  filt_b_reg <= wdata[FILT_B_W-1:0];
            MISC_LO:  misc_reg <= wdata;
            SCALE_LO: scale_reg[7:0] <= wdata;
            SCALE_HI: scale_reg[15:8] <= wdata;
            default:  ;
         endcase
      end
   end

   always_comb begin
      case ({addr[6:1], 1'b0})
         FILT_LO:  rd_word = {13'h0000, filt_b_reg};
         RANGE_LO: rd_word = {12'h000, range_reg,
                              RANGE_LOW_BITS};
         MISC_LO:  rd_word = {8'h00, misc_reg};
         SCALE_LO: rd_word = scale_reg;
         default:  rd_word = 16'h0000;
      endcase
   end

   // the word read goes out in the following frame
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         rd_word_reg <= 16'h0000;
      end else if (rd_stb) begin
         rd_word_reg <= rd_word;
      end
   end

   // ---------------- mode decode ----------------
   scsc_mode_t mode;
   logic       sync_pol;
   logic       dv_pol;

   assign mode     = scsc_mode_t'(misc_reg[MISC_MODE_HI:MISC_MODE_LO]);
   assign sync_pol = misc_reg[MISC_SYNC_POL];
   assign dv_pol   = misc_reg[MISC_DV_POL];

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         LIN_G_COMP_EN_O <= 1'b0;
         POP_ALIGN_EN_O  <= 1'b0;
         BW_LIMIT_EN_O   <= 1'b0;
      end else begin
         LIN_G_COMP_EN_O <= misc_reg[MISC_LIN_G];
         POP_ALIGN_EN_O  <= misc_reg[MISC_POP];
         BW_LIMIT_EN_O   <= (mode == MODE_PULSE);
      end
   end

   // ---------------- sample pin input ----------------
   logic [2:0] sync_reg;
   logic       any_edge;
   logic       act_edge;

   always_ff @(posedge CORE_CLK_I) begin
      sync_reg <= {sync_reg[1:0], SYNC_I};
   end

   assign any_edge = sync_reg[1] ^ sync_reg[2];
   assign act_edge = any_edge & (sync_reg[1] == sync_pol);

   // ---------------- internal timebase ----------------
   logic [31:0] int_cnt_reg;
   logic        int_half_reg;
   logic        int_acc_tick;

   assign int_acc_tick = (int_cnt_reg == 32'(ACC_PERIOD_CYC - 1));

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         int_cnt_reg  <= 32'h0;
         int_half_reg <= 1'b0;
      end else if (int_acc_tick) begin
         int_cnt_reg  <= 32'h0;
         int_half_reg <= ~int_half_reg;
      end else begin
         int_cnt_reg <= int_cnt_reg + 32'h1;
      end
   end

   // ---------------- scaled timebase ----------------
   // the multiplier is added every cycle; each time the sum passes
   // the measured input period one sample tick is made, so the
   // rate is input rate times multiplier without a divider. the
   // result tops out at one tick per core cycle.
   logic [31:0] per_cnt_reg;
   logic [31:0] period_reg;
   logic [31:0] acc_sum_reg;
   logic [31:0] acc_sum_next;
   logic        scaled_tick;

   assign acc_sum_next = acc_sum_reg + {16'h0000, scale_reg};
   assign scaled_tick  = (period_reg != 32'h0) &&
                         (acc_sum_next >= period_reg);

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || mode != MODE_SCALED) begin
         per_cnt_reg <= 32'h0;
         period_reg  <= 32'h0;
         acc_sum_reg <= 32'h0;
      end else if (act_edge) begin
         per_cnt_reg <= 32'h0;
         period_reg  <= per_cnt_reg + 32'h1;
         acc_sum_reg <= 32'h0;
      end else begin
         if (per_cnt_reg != 32'hffffffff) begin
            per_cnt_reg <= per_cnt_reg + 32'h1;
         end
         acc_sum_reg <= scaled_tick ? acc_sum_next - period_reg
                                    : acc_sum_next;
      end
   end

   // ---------------- tick selection ----------------
   logic gyro_tick;
   logic acc_tick;
   logic acc_pair;

   always_comb begin
      case (mode)
         MODE_DIRECT: begin
            gyro_tick = act_edge;
            acc_tick  = any_edge;
            acc_pair  = 1'b1;
         end
         MODE_SCALED: begin
            gyro_tick = scaled_tick;
            acc_tick  = scaled_tick;
            acc_pair  = 1'b0;
         end
         MODE_PULSE: begin
            gyro_tick = act_edge;
            acc_tick  = act_edge;
            acc_pair  = 1'b0;
         end
         default: begin
            gyro_tick = int_acc_tick & int_half_reg;
            acc_tick  = int_acc_tick;
            acc_pair  = 1'b1;
         end
      endcase
   end

   // ---------------- accelerometer pairing ----------------
   logic [DATA_W-1:0] acc_first_reg;
   logic [DATA_W:0]   acc_sum;

   assign acc_sum = {acc_first_reg[DATA_W-1], acc_first_reg}
                  + {ACCEL_RAW_I[DATA_W-1], ACCEL_RAW_I};

   // the pair closes on the gyro tick so both edges of one input
   // period land in the same update
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         acc_first_reg <= '0;
         ACCEL_AVG_O   <= '0;
         ACCEL_VALID_O <= 1'b0;
      end else begin
         ACCEL_VALID_O <= 1'b0;
         if (acc_tick && acc_pair && !gyro_tick) begin
            acc_first_reg <= ACCEL_RAW_I;
         end else if (acc_tick) begin
            ACCEL_VALID_O <= 1'b1;
            ACCEL_AVG_O   <= acc_pair ? acc_sum[DATA_W:1]
                                      : ACCEL_RAW_I;
         end
      end
   end

   // ---------------- gyro window filter ----------------
   logic              st1_valid;
   logic [DATA_W-1:0] st1_data;
   logic              st2_valid;

   // two equal boxcars in cascade form the triangular window
   scsc_avg_stage #(.W(DATA_W), .MAX_B(FILT_MAX_B)) u_stage1 (
      .clk_i       (CORE_CLK_I),
      .rst_i       (RST_I),
      .b_i         (filt_b_reg),
      .in_valid_i  (gyro_tick),
      .in_data_i   (GYRO_RAW_I),
      .out_valid_o (st1_valid),
      .out_data_o  (st1_data)
   );

   scsc_avg_stage #(.W(DATA_W), .MAX_B(FILT_MAX_B)) u_stage2 (
      .clk_i       (CORE_CLK_I),
      .rst_i       (RST_I),
      .b_i         (filt_b_reg),
      .in_valid_i  (st1_valid),
      .in_data_i   (st1_data),
      .out_valid_o (st2_valid),
      .out_data_o  (GYRO_FILT_O)
   );

   // ---------------- data valid pin ----------------
   logic [PULSE_CNT_W-1:0] dv_cnt_reg;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         dv_cnt_reg <= '0;
      end else if (st2_valid) begin
         dv_cnt_reg <= PULSE_CNT_W'(DV_HOLD_CYC);
      end else if (dv_cnt_reg != '0) begin
         dv_cnt_reg <= dv_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         DATA_VALID_PIN_O <= 1'b0;
      end else begin
         DATA_VALID_PIN_O <= (dv_cnt_reg != '0) ~^ dv_pol;
      end
   end

   // ---------------- sample pin output ----------------
   logic [PULSE_CNT_W-1:0] sync_cnt_reg;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || mode != MODE_OUT_PULSE) begin
         sync_cnt_reg <= '0;
      end else if (gyro_tick) begin
         sync_cnt_reg <= PULSE_CNT_W'(SYNC_PULSE_CYC);
      end else if (sync_cnt_reg != '0) begin
         sync_cnt_reg <= sync_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         SYNC_O        <= 1'b0;
         SYNC_OE_N_O   <= 1'b1;
         SAMPLE_TICK_O <= 1'b0;
      end else begin
         SYNC_O        <= (sync_cnt_reg != '0) ~^ sync_pol;
         SYNC_OE_N_O   <= (mode != MODE_OUT_PULSE);
         SAMPLE_TICK_O <= gyro_tick;
      end
   end
endmodule
`default_nettype wire

// ==== include/scsc_pkg.sv ====
package scsc_pkg;

   // register byte addresses on the serial port
   localparam int unsigned ADDR_W    = 7;
   localparam logic [6:0]  FILT_LO   = 7'h5c;
   localparam logic [6:0]  RANGE_LO  = 7'h5e;
   localparam logic [6:0]  MISC_LO   = 7'h60;
   localparam logic [6:0]  SCALE_LO  = 7'h62;
   localparam logic [6:0]  SCALE_HI  = 7'h63;

   // reset values
   localparam logic [2:0]  FILT_RESET  = 3'h0;
   localparam logic [7:0]  MISC_RESET  = 8'hc1;
   localparam logic [15:0] SCALE_RESET = 16'h07d0;

   // field positions
   localparam int unsigned FILT_B_W      = 3;
   localparam int unsigned FILT_MAX_B    = 7;
   localparam int unsigned MISC_LIN_G    = 7;
   localparam int unsigned MISC_POP      = 6;
   localparam int unsigned MISC_MODE_HI  = 4;
   localparam int unsigned MISC_MODE_LO  = 2;
   localparam int unsigned MISC_SYNC_POL = 1;
   localparam int unsigned MISC_DV_POL   = 0;
   localparam logic [1:0]  RANGE_LOW_BITS = 2'h3;

   // serial word layout
   localparam int unsigned SPI_WORD_W = 16;
   localparam int unsigned SPI_WR_BIT = 15;

   typedef enum logic [2:0] {
      MODE_INTERNAL  = 3'b000,
      MODE_DIRECT    = 3'b001,
      MODE_SCALED    = 3'b010,
      MODE_OUT_PULSE = 3'b011,
      MODE_PULSE     = 3'b101
   } scsc_mode_t;

   // timing
   localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   localparam int unsigned INT_RATE_HZ    = 2000;
   localparam int unsigned ACC_RATE_HZ    = 4000;
   localparam int unsigned INT_PERIOD_CYC = CLK_FREQ_HZ / INT_RATE_HZ;
   localparam int unsigned ACC_PERIOD_CYC = CLK_FREQ_HZ / ACC_RATE_HZ;
   localparam int unsigned SYNC_PULSE_NS  = 5000;
   localparam int unsigned SYNC_PULSE_CYC = SYNC_PULSE_NS * 1000
                                            / CLK_PERIOD_PS;
   localparam int unsigned DV_HOLD_NS     = 20000;
   localparam int unsigned DV_HOLD_CYC    = DV_HOLD_NS * 1000
                                            / CLK_PERIOD_PS;
   localparam int unsigned PULSE_CNT_W    = 16;

endpackage

// ==== src/scsc_spi_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsc_spi_slave (
   input  wire logic        clk_i,        // core clock
   input  wire logic        rst_i,        // sync reset, high
   input  wire logic        cs_n_i,       // chip select pin, async
   input  wire logic        sclk_i,       // serial clock pin, async
   input  wire logic        din_i,        // serial data in pin, async
   input  wire logic [15:0] rd_data_i,    // word sent in the next frame
   output logic             dout_o,       // serial data out
   output logic             wr_stb_o,     // one-cycle write strobe
   output logic             rd_stb_o,     // one-cycle read request
   output logic [6:0]       addr_o,       // captured address
   output logic [7:0]       data_o        // captured write byte
);
   import scsc_pkg::*;

   logic [2:0]  cs_reg;
   logic [2:0]  sclk_reg;
   logic [1:0]  din_reg;
   logic [15:0] rx_reg;
   logic [15:0] tx_reg;
   logic [4:0]  cnt_reg;
   logic        rise;
   logic        fall;
   logic        sel;

   // bit 0 of each stage is the first synchroniser flop
   always_ff @(posedge clk_i) begin
      cs_reg   <= {cs_reg[1:0], cs_n_i};
      sclk_reg <= {sclk_reg[1:0], sclk_i};
      din_reg  <= {din_reg[0], din_i};
   end

   assign sel  = ~cs_reg[1];
   assign rise = sel & sclk_reg[1] & ~sclk_reg[2];
   assign fall = sel & ~sclk_reg[1] & sclk_reg[2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_reg   <= 16'h0000;
         cnt_reg  <= 5'h00;
         wr_stb_o <= 1'b0;
         rd_stb_o <= 1'b0;
         addr_o   <= 7'h00;
         data_o   <= 8'h00;
      end else begin
         wr_stb_o <= 1'b0;
         rd_stb_o <= 1'b0;
         if (!sel) begin
            cnt_reg <= 5'h00;
         end else if (rise) begin
            rx_reg  <= {rx_reg[14:0], din_reg[1]};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == 5'(SPI_WORD_W - 1)) begin
               // first bit marks a write, then address, then data
               wr_stb_o <= rx_reg[SPI_WR_BIT - 1];
               rd_stb_o <= ~rx_reg[SPI_WR_BIT - 1];
               addr_o   <= rx_reg[13:7];
               data_o   <= {rx_reg[6:0], din_reg[1]};
            end
         end
      end
   end

   // mode 3 framing: shift out on falling edges, load at select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_reg <= 16'h0000;
         dout_o <= 1'b0;
      end else if (cs_reg[2] & ~cs_reg[1]) begin
         tx_reg <= rd_data_i;
      end else if (fall) begin
         dout_o <= tx_reg[15];
         tx_reg <= {tx_reg[14:0], 1'b0};
      end
   end
endmodule
`default_nettype wire

// ==== src/scsc_avg_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsc_avg_stage #(
   parameter int unsigned W     = 16,     // sample width
   parameter int unsigned MAX_B = 7       // largest tap exponent
) (
   input  wire logic         clk_i,       // core clock
   input  wire logic         rst_i,       // sync reset, high
   input  wire logic [2:0]   b_i,         // tap exponent
   input  wire logic         in_valid_i,  // new sample strobe
   input  wire logic [W-1:0] in_data_i,   // signed sample
   output logic              out_valid_o, // averaged sample strobe
   output logic [W-1:0]      out_data_o   // signed average
);
   localparam int unsigned DEPTH = 1 << MAX_B;
   localparam int unsigned SW    = W + MAX_B + 1;

   if (MAX_B < 1 || MAX_B > 7) begin : g_bad_b
      $error("scsc_avg_stage: MAX_B must be 1 to 7");
   end

   logic [W-1:0]         mem [DEPTH];
   logic [MAX_B-1:0]     ptr_reg;
   logic [MAX_B:0]       fill_reg;
   logic signed [SW-1:0] sum_reg;
   logic signed [SW-1:0] sum_next;
   logic [2:0]           b_reg;
   logic [MAX_B-1:0]     old_idx;
   logic [MAX_B:0]       taps;
   logic signed [W-1:0]  old_val;

   assign taps     = (MAX_B + 1)'(1) << b_i;
   assign old_idx  = ptr_reg - taps[MAX_B-1:0];
   assign old_val  = (fill_reg >= taps) ? mem[old_idx] : '0;
   assign sum_next = sum_reg + SW'(signed'(in_data_i)) - SW'(old_val);

   always_ff @(posedge clk_i) begin
      if (in_valid_i) begin
         mem[ptr_reg] <= in_data_i;
      end
   end

   // a new size restarts the window so no stale taps leak in
   always_ff @(posedge clk_i) begin
      b_reg <= b_i;
      if (rst_i || b_reg != b_i) begin
         ptr_reg     <= '0;
         fill_reg    <= '0;
         sum_reg     <= '0;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else begin
         out_valid_o <= in_valid_i;
         if (in_valid_i) begin
            ptr_reg    <= ptr_reg + 1'b1;
            sum_reg    <= sum_next;
            out_data_o <= W'(sum_next >>> b_i);
            if (fill_reg < taps) begin
               fill_reg <= fill_reg + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/scsc_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsc_chk #(
   parameter int unsigned INT_PERIOD_CYC = 100000,
   parameter int unsigned ACC_PERIOD_CYC = 50000,
   parameter int unsigned DATA_W         = 16
) (
   input wire logic              CORE_CLK_I,       // core clock
   input wire logic              RST_I,            // sync reset
   input wire logic              SPI_CS_N_I,       // serial select
   input wire logic              SYNC_I,           // sample pin level
   input wire logic              SYNC_O,           // sample pin drive
   input wire logic              SYNC_OE_N_O,      // low while driving
   input wire logic [DATA_W-1:0] GYRO_FILT_O,      // filtered gyro
   input wire logic              ACCEL_VALID_O,    // accel update
   input wire logic              DATA_VALID_PIN_O, // data valid pin
   input wire logic              LIN_G_COMP_EN_O,  // g comp on
   input wire logic              POP_ALIGN_EN_O,   // align on
   input wire logic              BW_LIMIT_EN_O,    // bandwidth limit
   input wire logic              SAMPLE_TICK_O     // sample tick
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   logic [4:0] cs_idle;
   logic [3:0] sync_age;
   // settings only move during or just after a serial frame
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || !SPI_CS_N_I) cs_idle <= '0;
      else if (cs_idle != 5'h1f) cs_idle <= cs_idle + 5'h01;
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || $changed(SYNC_I)) sync_age <= '0;
      else if (sync_age != 4'hf) sync_age <= sync_age + 4'h1;
   end
   cfg_hold_a: assert property (($changed(LIN_G_COMP_EN_O)
      || $changed(POP_ALIGN_EN_O) || $changed(BW_LIMIT_EN_O)
      || $changed(SYNC_OE_N_O)) |-> cs_idle < 5'h14)
      else $error("control output moved without a write");
   bw_no_drive_a: assert property (BW_LIMIT_EN_O |-> SYNC_OE_N_O)
      else $error("bandwidth limit while driving sample pin");
   out_tick_a: assert property (SAMPLE_TICK_O && !SYNC_OE_N_O
      |=> !SAMPLE_TICK_O [*8])
      else $error("internal ticks too close");
   sync_pulse_a: assert property ($changed(SYNC_O) && !SYNC_OE_N_O
      && $past(!SYNC_OE_N_O) |=> $stable(SYNC_O) [*8])
      else $error("sample pin pulse too short");
   gyro_on_tick_a: assert property ($changed(GYRO_FILT_O) |->
      SAMPLE_TICK_O || $past(SAMPLE_TICK_O) || $past(SAMPLE_TICK_O, 2))
      else $error("filter output moved without a tick");
   dv_hold_a: assert property ($changed(DATA_VALID_PIN_O)
      |=> $stable(DATA_VALID_PIN_O) [*8])
      else $error("data valid pin glitch");
   pulse_tick_a: assert property (SAMPLE_TICK_O && BW_LIMIT_EN_O
      && $past(BW_LIMIT_EN_O, 8) |-> sync_age inside {[1:6]})
      else $error("pulse mode tick without pin edge");
   pulse_acc_a: assert property (ACCEL_VALID_O && BW_LIMIT_EN_O
      && $past(BW_LIMIT_EN_O, 8) |-> sync_age inside {[1:10]})
      else $error("pulse mode accel without pin edge");
   cover property (SAMPLE_TICK_O && BW_LIMIT_EN_O);
   cover property (SAMPLE_TICK_O && !SYNC_OE_N_O);
   cover property ($changed(DATA_VALID_PIN_O));
endmodule
bind scsc_top scsc_chk #(
   .INT_PERIOD_CYC(INT_PERIOD_CYC),
   .ACC_PERIOD_CYC(ACC_PERIOD_CYC),
   .DATA_W(DATA_W)
) u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .SPI_CS_N_I(SPI_CS_N_I),
   .SYNC_I(SYNC_I), .SYNC_O(SYNC_O), .SYNC_OE_N_O(SYNC_OE_N_O),
   .GYRO_FILT_O(GYRO_FILT_O), .ACCEL_VALID_O(ACCEL_VALID_O),
   .DATA_VALID_PIN_O(DATA_VALID_PIN_O), .LIN_G_COMP_EN_O(LIN_G_COMP_EN_O),
   .POP_ALIGN_EN_O(POP_ALIGN_EN_O), .BW_LIMIT_EN_O(BW_LIMIT_EN_O),
   .SAMPLE_TICK_O(SAMPLE_TICK_O));
`default_nettype wire

// ==== tb/scsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsc_host_model (
   input  wire logic dout_i, // device serial out
   output logic      cs_n_o, // select
   output logic      sclk_o, // idles high between frames
   output logic      din_o,  // serial data to device
   output logic      sync_o  // sample pin drive
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
      din_o  = 1'b0;
      sync_o = 1'b0;
   end
   // one word per frame, msb first, 160 ns link period
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      r      = '0;
      cs_n_o = 1'b0;
      #80;
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         din_o  = w[i];
         #80;
         sclk_o = 1'b1;
         r      = {r[14:0], dout_i};
         #80;
      end
      cs_n_o = 1'b1;
      din_o  = ~din_o;  // released line must not look held
      #100;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      if (a == 7'h60) d[5] = 1'b0;
      xfer({1'b1, a, d}, r);
   endtask
   // read answer only arrives in the following frame
   task automatic rd(input logic [6:0] a, output logic [15:0] v);
      xfer({1'b0, a, 8'h00}, v);
      xfer({1'b0, a, 8'h00}, v);
   endtask
   task automatic pin(input logic v);
      sync_o = v;
   endtask
endmodule
`default_nettype wire

// ==== tb/scsc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsc_top_tb;
   import scsc_pkg::*;
   localparam int IP = 2000;
   logic        clk, rst, cs_n, sclk, din, dout, hsync, sdrv, oe_n, pin;
   logic        avalid, dv, ling, pop, bw, tick;
   logic [15:0] graw, araw, gfilt, aavg, v;
   int          errors, samples_checked, nt, na, s;
   real         t0;
   assign pin = oe_n ? hsync : sdrv;
   scsc_host_model host (.dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk),
      .din_o(din), .sync_o(hsync));
   scsc_top #(.INT_PERIOD_CYC(IP), .ACC_PERIOD_CYC(IP / 2)) dut (
      .CORE_CLK_I(clk), .RST_I(rst), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk),
      .SPI_DIN_I(din), .SPI_DOUT_O(dout), .SYNC_I(pin), .SYNC_O(sdrv),
      .SYNC_OE_N_O(oe_n), .GYRO_RANGE_I(2'b01), .GYRO_RAW_I(graw),
      .ACCEL_RAW_I(araw), .GYRO_FILT_O(gfilt), .ACCEL_AVG_O(aavg),
      .ACCEL_VALID_O(avalid), .DATA_VALID_PIN_O(dv), .LIN_G_COMP_EN_O(ling),
      .POP_ALIGN_EN_O(pop), .BW_LIMIT_EN_O(bw), .SAMPLE_TICK_O(tick));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_for(input bit acc, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(negedge clk);
         if ((acc ? avalid : tick) === 1'b1) return;
      end
      errors++;
      complete_run;
   endtask
   task automatic watch(input int n);
      nt = 0;
      na = 0;
      repeat (n) begin
         @(negedge clk);
         if (tick === 1'b1) nt++;
         if (avalid === 1'b1) na++;
      end
   endtask
   task automatic t_regs;
      host.rd(FILT_LO, v);  chk(v, 16'h0000);
      host.rd(MISC_LO, v);  chk(v, 16'h00c1);
      host.rd(SCALE_LO, v); chk(v, SCALE_RESET);
      host.rd(RANGE_LO, v); chk(v, 16'h0007);
      host.rd(7'h70, v);    chk(v, 16'h0000);
      host.wr(RANGE_LO, 8'h00);
      host.wr(7'h5d, 8'hff);
      host.wr(FILT_LO, 8'hf9);
      host.wr(SCALE_LO, 8'h34);
      host.wr(SCALE_HI, 8'h12);
      host.rd(FILT_LO, v);  chk(v, 16'h0001);
      host.rd(RANGE_LO, v); chk(v, 16'h0007);
      host.rd(SCALE_LO, v); chk(v, 16'h1234);
   endtask
   task automatic t_ctrl;
      host.wr(MISC_LO, 8'h01); chk(16'({ling, pop}), 16'h0000);
      host.wr(MISC_LO, 8'h81); chk(16'({ling, pop}), 16'h0002);
      host.wr(MISC_LO, 8'h41); chk(16'({ling, pop}), 16'h0001);
   endtask
   // output pulse mode, rising active, valid high
   task automatic t_out;
      graw = 16'h0040;
      host.wr(MISC_LO, 8'hcf);
      chk(16'(oe_n), 16'h0000);
      wait_for(0, 3 * IP);
      t0 = $realtime;
      repeat (5) @(negedge clk);
      chk(16'(sdrv), 16'h0001);
      chk(16'(dv), 16'h0001);
      wait_for(0, 2 * IP);
      chk(16'(int'(($realtime - t0) / 5.0)), 16'(IP));
      repeat (1100) @(negedge clk);
      chk(16'(sdrv), 16'h0000);
      wait_for(1, IP);
      t0 = $realtime;
      // one update per internal period, pairing two half-period samples
      araw = 16'h0010;
      repeat (IP / 2) @(negedge clk);
      araw = 16'h0030;
      wait_for(1, IP);
      chk(16'(int'(($realtime - t0) / 5.0)), 16'(IP));
      chk(aavg, 16'h0020);
      repeat (8) wait_for(0, 2 * IP);
      chk(gfilt, 16'h0040);
      host.wr(MISC_LO, 8'hce);
      chk(16'(dv), 16'h0000);
   endtask
   // mode codes used: 000 011 001 101 010, never reserved
   task automatic t_direct(input logic pol);
      host.wr(MISC_LO, {6'b110001, pol, 1'b1});
      host.pin(pol);
      watch(200);
      araw = 16'h0010;
      host.pin(~pol); // 50% duty
      watch(200);
      chk(16'(nt + na), 16'h0000);
      araw = 16'h0030;
      host.pin(pol);
      watch(200);
      chk(16'({nt[3:0], na[3:0]}), 16'h0011);
      chk(aavg, 16'h0020);
   endtask
   task automatic t_pulse;
      host.wr(MISC_LO, 8'hd7);
      chk(16'(bw), 16'h0001);
      araw = 16'h0055;
      host.pin(1'b1); // narrow pulse
      watch(20);
      s = 16 * nt + na;
      host.pin(1'b0);
      watch(300);
      chk(16'(s + 16 * nt + na), 16'h0011);
      chk(aavg, 16'h0055);
   endtask
   task automatic t_scaled;
      host.wr(SCALE_LO, 8'h04);
      host.wr(SCALE_HI, 8'h00);
      host.wr(MISC_LO, 8'hcb);
      for (int i = 0; i < 4; i++) begin
         host.pin(1'b1);
         watch(400);
         s = nt;
         host.pin(1'b0);
         watch(400);
      end
      chk(16'(s + nt), 16'h0004);
   endtask
   initial begin
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      graw = '0;
      araw = '0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_regs;
      t_ctrl;
      t_out;
      t_direct(1'b1);
      t_direct(1'b0);
      t_pulse;
      t_scaled;
      complete_run;
   end
endmodule
`default_nettype wire
